// ===== pkg/pisc_pkg.sv
/*
  Constants and types shared by the PHY interrupt status/control block.
  Assumes a clause-22 style management frame and a 16-bit register space.
*/
package pisc_pkg;
  // Register indices and the broadcast PHY address on the management interface
  localparam logic [4:0] REG_ICSR      = 5'h1b;
  localparam logic [4:0] REG_CABLE     = 5'h1d;
  localparam logic [4:0] REG_CTRL2     = 5'h1f;
  localparam logic [4:0] BCAST_ADDR    = 5'h00;
  // Field layout
  localparam int         N_EVENTS      = 8;
  localparam int         EN_LSB        = 8;
  localparam int         CAB_EN_BIT    = 15;
  localparam int         INT_LEVEL_BIT = 9;
  localparam int         EV_LINK_UP    = 0;
  localparam int         EV_PAGE       = 5;
  localparam int         EV_RX_ERR     = 6;
  localparam int         EV_JABBER     = 7;
  // Reset values
  localparam logic [7:0] EN_RST        = 8'h00;
  localparam logic [7:0] FLAG_RST      = 8'h00;
  localparam logic       CAB_RST       = 1'h0;
  localparam logic       INT_LEVEL_RST = 1'h0;
  localparam logic       INT_PIN_RST   = 1'h1;
  // Frame layout and counts
  localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
  localparam logic [4:0] HDR_LAST      = 5'h0d;
  localparam logic [4:0] DATA_LAST     = 5'h0f;
  localparam logic [1:0] ST_CODE       = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;

  typedef enum logic [1:0]
  {
    PISC_PRE  = 2'h0,
    PISC_HDR  = 2'h1,
    PISC_TA   = 2'h3,
    PISC_DATA = 2'h2
  } pisc_mdio_e;
endpackage : pisc_pkg

// ===== pkg/pisc_reg_if.sv
/*
  Register access strobes from the frame decoder to the register banks.
  Assumes one-cycle wr/rd strobes on core_clk and combinational read data.
*/
`timescale 1ns/10ps
interface pisc_reg_if;
  logic        wr;
  logic        rd;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] icsr_rdata;
  logic [15:0] cab_rdata;

  modport master (output wr, rd, addr, wdata, input icsr_rdata, cab_rdata);
  modport icsr   (input wr, rd, addr, wdata, output icsr_rdata);
  modport cable  (input wr, addr, wdata, output cab_rdata);
endinterface : pisc_reg_if

// ===== verilog/pisc_event_flags.sv
/*
  Event flags and enables of the interrupt control/status register.
  Assumes link events are one-cycle pulses from logic on core_clk.
*/
`timescale 1ns/10ps
module pisc_event_flags
  import pisc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  pisc_reg_if.icsr                 rif,
  input  wire logic [N_EVENTS-1:0] link_events,
  output logic                     irq_req
);
  logic [N_EVENTS-1:0] enable;
  logic [N_EVENTS-1:0] flag;

  wire                 hit         = (rif.addr == REG_ICSR);
  wire                 rd_clear    = rif.rd && hit;
  wire [N_EVENTS-1:0]  next_enable = (rif.wr && hit) ? rif.wdata[EN_LSB +: N_EVENTS] : enable; // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
  // Set wins over the clearing read, so no event is lost
  wire [N_EVENTS-1:0]  next_flag   = (flag & ~{N_EVENTS{rd_clear}}) | link_events; // RL9 RL10 RL11 RL12 RL13 RL14 RL15 RL16

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable <= EN_RST;
      flag   <= FLAG_RST;
    end
    else
    begin
      enable <= next_enable;
      flag   <= next_flag;
    end
  end

  assign rif.icsr_rdata = {enable, flag};
  assign irq_req        = |(flag & enable); // RL20

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_flag_hold;
    (flag[EV_JABBER] && !rd_clear) |=> flag[EV_JABBER];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read"); // RL9

  property p_flag_set;
    link_events[EV_RX_ERR] |=> flag[EV_RX_ERR] ##1 (flag[EV_RX_ERR] || $past(rd_clear));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag"); // RL10

  property p_flag_clear;
    (rd_clear && !link_events[EV_PAGE]) |=> !flag[EV_PAGE];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag"); // RL11
endmodule : pisc_event_flags

// ===== verilog/pisc_cable_test.sv
/*
  Start and self-clearing completion bit of the cable diagnostic test.
  Assumes the test engine answers a start pulse with a done pulse.
*/
`timescale 1ns/10ps
module pisc_cable_test
  import pisc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  pisc_reg_if.cable rif,
  input  wire logic cable_done,
  output logic      cable_start
);
  logic run;

  // A start while running is ignored; the test cannot be retriggered
  wire start_req = rif.wr && (rif.addr == REG_CABLE) && rif.wdata[CAB_EN_BIT] && !run; // RL17
  wire next_run  = start_req || (run && !cable_done); // RL17

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      run         <= CAB_RST;
      cable_start <= 1'h0;
    end
    else
    begin
      run         <= next_run;
      cable_start <= start_req;
    end
  end

  // Result fields live in the test engine and read as zero here
  assign rif.cab_rdata = 16'(run) << CAB_EN_BIT; // RL18

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  wire cab_bit = rif.cab_rdata[CAB_EN_BIT];

  property p_cab_start;
    (rif.wr && (rif.addr == REG_CABLE) && rif.wdata[CAB_EN_BIT] && !cab_bit)
      |=> (cab_bit && cable_start) ##1 !cable_start;
  endproperty
  a_cab_start: assert property (p_cab_start) else $error("cable test did not start"); // RL17

  property p_cab_hold;
    (cab_bit && !cable_done) |=> cab_bit;
  endproperty
  a_cab_hold: assert property (p_cab_hold) else $error("test bit cleared early"); // RL18

  property p_cab_done;
    (cab_bit && cable_done) |=> !cab_bit;
  endproperty
  a_cab_done: assert property (p_cab_done) else $error("test bit did not self-clear"); // RL17

  c_cab_done: cover property (cab_bit ##1 !cab_bit);
endmodule : pisc_cable_test

// ===== verilog/pisc_top.sv
/*
  Top of the PHY interrupt status/control block: management frame slave,
  register read mux, interrupt pin and the two register banks.
  Assumes MDC runs at least ten times slower than core_clk, every frame
  carries a full preamble, and link events come from logic on core_clk.
*/
// Summary of operation
// RL1: Jabber interrupt enable, writable, resets to zero
// RL2: Receive error interrupt enable, resets to zero
// RL3: Page received interrupt enable, resets to zero
// RL4: Parallel detect fault interrupt enable, resets zero
// RL5: Partner acknowledge interrupt enable, resets to zero
// RL6: Link-down interrupt enable, resets to zero
// RL7: Remote fault interrupt enable, resets to zero
// RL8: Link-up interrupt enable, resets to zero
// RL9: Jabber flag sticks until read, resets zero
// RL10: Receive error flag sticky, cleared by read
// RL11: Page received flag sticky, cleared by read
// RL12: Parallel detect fault flag sticky, read clears
// RL13: Partner acknowledge flag sticky, read clears
// RL14: Link-down flag sticky, read clears
// RL15: Remote fault flag sticky, read clears
// RL16: Link-up flag sticky, read clears
// RL17: Writing one starts cable test, self-clears
// RL18: Cleared test bit means results are valid
// RL19: Level bit selects interrupt pin polarity
// RL20: Pin active while any enabled flag set
`timescale 1ns/10ps
module pisc_top
  import pisc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
)
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                mdc,
  input  wire logic                mdio_in,
  output logic                     mdio_out,
  output logic                     mdio_oe,
  input  wire logic [N_EVENTS-1:0] link_events,
  input  wire logic                cable_done,
  output logic                     cable_start,
  output logic                     int_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]  mdc_sync;
  logic [1:0]  mdio_sync;
  logic        mdc_prev;
  pisc_mdio_e  state;
  pisc_mdio_e  next_state;
  logic [5:0]  ones;
  logic [5:0]  next_ones;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [12:0] hdr;
  logic [12:0] next_hdr;
  logic        is_rd;
  logic        next_is_rd;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic        rd_strobe;
  logic        next_rd;
  logic        wr_strobe;
  logic        next_wr;
  logic [4:0]  reg_addr;
  logic [4:0]  next_addr;
  logic        next_oe;
  logic        next_out;
  logic        int_level;
  logic        irq_req;

  pisc_reg_if rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  function automatic logic [15:0] pisc_rd_mux
  (
    input logic [4:0]  a,
    input logic [15:0] icsr,
    input logic [15:0] cab,
    input logic        lvl
  );
    if (a == REG_ICSR)
      return icsr;
    else if (a == REG_CABLE)
      return cab;
    else if (a == REG_CTRL2)
      return 16'(lvl) << INT_LEVEL_BIT;
    else
      return 16'h0000;
  endfunction : pisc_rd_mux

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mdc_sync  <= 2'h0;
      mdio_sync <= 2'h3;
      mdc_prev  <= 1'h0;
    end
    else
    begin
      mdc_sync  <= {mdc_sync[0], mdc};
      mdio_sync <= {mdio_sync[0], mdio_in};
      mdc_prev  <= mdc_sync[1];
    end
  end

  wire         mdc_rise  = mdc_sync[1] && !mdc_prev;
  wire         bit_in    = mdio_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame header decode
  wire [13:0]  hdr_full  = {hdr, bit_in};
  wire [1:0]   f_st      = hdr_full[13:12];
  wire [1:0]   f_op      = hdr_full[11:10];
  wire [4:0]   f_pa      = hdr_full[9:5];
  wire [4:0]   f_ra      = hdr_full[4:0];
  wire         addr_hit  = (f_pa == PHY_ADDR) || (f_pa == BCAST_ADDR);
  wire         op_rd     = (f_op == OP_READ);
  wire         op_wr     = (f_op == OP_WRITE);
  wire         hdr_ok    = (f_st == ST_CODE) && addr_hit && (op_rd || op_wr);
  wire         pre_done  = (ones == PREAMBLE_LEN);
  wire [15:0]  rdata_mux = pisc_rd_mux(reg_addr, rif.icsr_rdata, rif.cab_rdata, int_level);

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine, advanced on each rising MDC
  always_comb
  begin
    next_state = state;
    next_ones  = ones;
    next_cnt   = cnt;
    next_hdr   = hdr;
    next_is_rd = is_rd;
    next_sh    = sh;
    next_rd    = 1'h0;
    next_wr    = 1'h0;
    next_addr  = reg_addr;
    next_oe    = mdio_oe;
    next_out   = mdio_out;
    // Snapshot is taken in the same cycle the flags clear
    if (rd_strobe)
      next_sh = rdata_mux; // RL9
    if (mdc_rise)
    begin
      case (state)
        PISC_PRE:
        begin
          if (bit_in)
            next_ones = pre_done ? ones : 6'(ones + 6'h01);
          else
          begin
            next_ones = 6'h00;
            if (pre_done)
            begin
              next_state = PISC_HDR;
              next_cnt   = 5'h01;
              next_hdr   = 13'h0000;
            end
          end
        end
        PISC_HDR:
        begin
          next_hdr = {hdr[11:0], bit_in};
          next_cnt = 5'(cnt + 5'h01);
          if (cnt == HDR_LAST)
          begin
            if (hdr_ok)
            begin
              next_state = PISC_TA;
              next_cnt   = 5'h00;
              next_is_rd = op_rd;
              next_addr  = f_ra;
              next_rd    = op_rd;
            end
            else
              next_state = PISC_PRE;
          end
        end
        PISC_TA:
        begin
          next_cnt = 5'(cnt + 5'h01);
          if (cnt == 5'h00)
          begin
            // Drive the second turnaround bit low
            if (is_rd)
            begin
              next_oe  = 1'h1;
              next_out = 1'h0;
            end
          end
          else
          begin
            next_state = PISC_DATA;
            next_cnt   = 5'h00;
            if (is_rd)
            begin
              next_out = sh[15];
              next_sh  = {sh[14:0], 1'h0};
            end
          end
        end
        PISC_DATA:
        begin
          next_cnt = 5'(cnt + 5'h01);
          if (is_rd)
          begin
            if (cnt == DATA_LAST)
            begin
              next_oe    = 1'h0;
              next_state = PISC_PRE;
            end
            else
            begin
              next_out = sh[15];
              next_sh  = {sh[14:0], 1'h0};
            end
          end
          else
          begin
            next_sh = {sh[14:0], bit_in};
            if (cnt == DATA_LAST)
            begin
              next_wr    = 1'h1;
              next_state = PISC_PRE;
            end
          end
        end
        default:
          next_state = PISC_PRE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= PISC_PRE;
      ones      <= 6'h00;
      cnt       <= 5'h00;
      hdr       <= 13'h0000;
      is_rd     <= 1'h0;
      sh        <= 16'h0000;
      rd_strobe <= 1'h0;
      wr_strobe <= 1'h0;
      reg_addr  <= 5'h00;
      mdio_oe   <= 1'h0;
      mdio_out  <= 1'h0;
    end
    else
    begin
      state     <= next_state;
      ones      <= next_ones;
      cnt       <= next_cnt;
      hdr       <= next_hdr;
      is_rd     <= next_is_rd;
      sh        <= next_sh;
      rd_strobe <= next_rd;
      wr_strobe <= next_wr;
      reg_addr  <= next_addr;
      mdio_oe   <= next_oe;
      mdio_out  <= next_out;
    end
  end

  assign rif.wr    = wr_strobe;
  assign rif.rd    = rd_strobe;
  assign rif.addr  = reg_addr;
  assign rif.wdata = sh;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin
  wire ctrl2_wr   = wr_strobe && (reg_addr == REG_CTRL2);
  wire next_level = ctrl2_wr ? sh[INT_LEVEL_BIT] : int_level; // RL19
  // Registered so the pin never glitches between flag updates
  wire next_pin   = int_level ? irq_req : !irq_req; // RL19 RL20

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_level <= INT_LEVEL_RST;
      int_pin   <= INT_PIN_RST;
    end
    else
    begin
      int_level <= next_level;
      int_pin   <= next_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register banks
  pisc_event_flags u_flags
  (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .rif         (rif.icsr),
    .link_events (link_events),
    .irq_req     (irq_req)
  );

  pisc_cable_test u_cable
  (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .rif         (rif.cable),
    .cable_done  (cable_done),
    .cable_start (cable_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  wire icsr_rd  = rd_strobe && (reg_addr == REG_ICSR);
  wire icsr_wr  = wr_strobe && (reg_addr == REG_ICSR);

  property p_en_write;
    icsr_wr |=> (rif.icsr_rdata[EN_LSB +: N_EVENTS] == $past(sh[EN_LSB +: N_EVENTS]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable field missed write"); // RL1

  property p_en_gate;
    (rif.icsr_rdata[EN_LSB +: N_EVENTS] == 8'h00) |-> !irq_req;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("disabled flag raised request"); // RL2

  property p_page_gate;
    (!rif.icsr_rdata[EN_LSB + EV_PAGE] && link_events[EV_PAGE] && !icsr_wr && !irq_req
      && ((link_events & rif.icsr_rdata[EN_LSB +: N_EVENTS]) == 8'h00)) |=> !irq_req;
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("masked page event raised request"); // RL3

  property p_read_snap;
    icsr_rd |=> (sh == $past(rif.icsr_rdata));
  endproperty
  a_read_snap: assert property (p_read_snap) else $error("read data not captured"); // RL12

  property p_pin_on;
    irq_req |=> (int_pin == $past(int_level));
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not active with request"); // RL19

  property p_pin_off;
    !irq_req |=> (int_pin != $past(int_level));
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin active without request"); // RL20

  c_flag_read:  cover property (icsr_rd && (rif.icsr_rdata[N_EVENTS-1:0] != 8'h00));
  c_irq_high:   cover property (int_level && int_pin);
  c_mdio_write: cover property (icsr_wr);
endmodule : pisc_top

// ===== verification/pisc_mgmt_model.sv
/*
  Management controller model: sends clause-22 frames on mdc/mdio.
  Assumes a pull-up on mdio and core_clk at least ten times mdc.
*/
`timescale 1ns/10ps
module pisc_mgmt_model
  import pisc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      mdc,
  output wire logic mdio_line
);
  logic m_en;
  logic m_out;

  // Released line rests at the pull-up level, not the last bit
  assign mdio_line = dev_oe ? dev_out : (m_en ? m_out : 1'b1);

  initial
  begin
    mdc   = 1'b0;
    m_en  = 1'b0;
    m_out = 1'b1;
  end

  ////////////////////////////////////////
  // One mdc period of 12 core clocks; sample just before the rise
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    @(posedge core_clk);
    mdc   <= 1'b0;
    m_en  <= drv;
    m_out <= val;
    repeat (5) @(posedge core_clk);
    smp = mdio_line;
    @(posedge core_clk);
    mdc <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask : bit_cycle

  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        w;
    hdr = {ST_CODE, op, pa, ra};
    w   = (op == OP_WRITE);
    rd  = 16'h0000;
    for (int i = 0; i < 32; i++)
      bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      bit_cycle(1'b1, hdr[i], s);
    bit_cycle(w, 1'b1, s);
    bit_cycle(w, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_cycle(w, wd[i], s);
      rd[i] = s;
    end
    // Clock stands low between frames; leave time for the write to land
    @(posedge core_clk);
    mdc  <= 1'b0;
    m_en <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : xfer
endmodule : pisc_mgmt_model

// ===== verification/pisc_top_tb.sv
/*
  Self-checking bench for pisc_top: enables, flags, pin polarity, cable bit.
  Assumes pisc_mgmt_model as the management controller on mdc/mdio.
*/
`timescale 1ns/10ps
module pisc_top_tb
  import pisc_pkg::*;
;
  localparam logic [4:0] PHY_A = 5'h03;
  localparam int         LIMIT = 80000;

  typedef struct {logic [7:0] ev; logic [7:0] en; logic lvl; logic pin;} pisc_row_s;

  logic        core_clk = 1'b0;
  logic        rstn;
  logic        mdc;
  wire logic   mdio_line;
  logic        mdio_out;
  logic        mdio_oe;
  logic [7:0]  link_events;
  logic        cable_done;
  logic        cable_start;
  logic        int_pin;
  logic [15:0] rdat;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          starts    = 0;

  pisc_row_s rows [10] = '{
    '{8'h80, 8'h80, 1'b0, 1'b0},
    '{8'h40, 8'h40, 1'b1, 1'b1},
    '{8'h20, 8'h20, 1'b0, 1'b0},
    '{8'h10, 8'h10, 1'b1, 1'b1},
    '{8'h08, 8'h08, 1'b0, 1'b0},
    '{8'h04, 8'h04, 1'b1, 1'b1},
    '{8'h02, 8'h02, 1'b0, 1'b0},
    '{8'h01, 8'h01, 1'b1, 1'b1},
    '{8'hff, 8'h00, 1'b0, 1'b1},  // Events with all enables off
    '{8'h0f, 8'hf0, 1'b1, 1'b0}   // Enables on other events only
  };

  pisc_top #(.PHY_ADDR(PHY_A)) pisc_top_inst (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .mdc         (mdc),
    .mdio_in     (mdio_line),
    .mdio_out    (mdio_out),
    .mdio_oe     (mdio_oe),
    .link_events (link_events),
    .cable_done  (cable_done),
    .cable_start (cable_start),
    .int_pin     (int_pin)
  );

  pisc_mgmt_model pisc_mgmt_model_inst (
    .core_clk  (core_clk),
    .dev_out   (mdio_out),
    .dev_oe    (mdio_oe),
    .mdc       (mdc),
    .mdio_line (mdio_line)
  );

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cable_start === 1'b1)
      starts <= starts + 1;
    if (cycles == LIMIT)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  ////////////////////////////////////////
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] pa = PHY_A);
    logic [15:0] dummy;
    pisc_mgmt_model_inst.xfer(OP_WRITE, pa, ra, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] got;
    pisc_mgmt_model_inst.xfer(OP_READ, PHY_A, ra, 16'h0000, got);
    chk16(got, exp);
  endtask : rd_chk

  task automatic pulse(input logic [7:0] ev, input logic dn);
    @(posedge core_clk);
    link_events <= ev;
    cable_done  <= dn;
    @(posedge core_clk);
    link_events <= 8'h00;
    cable_done  <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////
  initial
  begin
    rstn        = 1'b0;
    link_events = 8'h00;
    cable_done  = 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (rows[i])
    begin
      wr(REG_CTRL2, {6'h00, rows[i].lvl, 9'h000});
      wr(REG_ICSR, {rows[i].en, 8'hff});
      chk1(int_pin, ~rows[i].lvl);
      pulse(rows[i].ev, 1'b0);
      repeat (3) @(negedge core_clk);
      chk1(int_pin, rows[i].pin);
      rd_chk(REG_ICSR, {rows[i].en, rows[i].ev});
      repeat (3) @(negedge core_clk);
      chk1(int_pin, ~rows[i].lvl);
      rd_chk(REG_ICSR, {rows[i].en, 8'h00});
      rd_chk(REG_CTRL2, {6'h00, rows[i].lvl, 9'h000});
    end
    // Frames for other addresses are ignored; address 0 is broadcast
    wr(REG_ICSR, 16'h5500, 5'h02);
    rd_chk(REG_ICSR, 16'hf000);
    // Reserved opcode is refused: the line stays at the pull-up level
    pisc_mgmt_model_inst.xfer(2'h3, PHY_A, REG_ICSR, 16'h5500, rdat);
    chk16(rdat, 16'hffff);
    rd_chk(REG_ICSR, 16'hf000);
    wr(REG_ICSR, 16'h5500, 5'h00);
    rd_chk(REG_ICSR, 16'h5500);
    rd_chk(5'h1c, 16'h0000);
    // Cable test: done while idle, start, ignored writes, completion
    pulse(8'h00, 1'b1);
    rd_chk(REG_CABLE, 16'h0000);
    wr(REG_CABLE, 16'h8000);
    chk16(16'(starts), 16'h0001);
    rd_chk(REG_CABLE, 16'h8000);
    wr(REG_CABLE, 16'h0000);
    wr(REG_CABLE, 16'h8000);
    rd_chk(REG_CABLE, 16'h8000);
    chk16(16'(starts), 16'h0001);
    pulse(8'h00, 1'b1);
    rdat = 16'h8000;
    for (int k = 0; k < 4 && rdat[15] !== 1'b0; k++)
      pisc_mgmt_model_inst.xfer(OP_READ, PHY_A, REG_CABLE, 16'h0000, rdat);
    chk16(rdat, 16'h0000);
    // Reset in mid-run with an interrupt pending
    wr(REG_CTRL2, 16'h0000);
    wr(REG_ICSR, 16'hff00);
    pulse(8'h01, 1'b0);
    repeat (3) @(negedge core_clk);
    chk1(int_pin, 1'b0);
    @(posedge core_clk);
    rstn <= 1'b0;
    @(negedge core_clk);
    chk1(int_pin, 1'b1);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(REG_ICSR, 16'h0000);
    rd_chk(REG_CABLE, 16'h0000);
    rd_chk(REG_CTRL2, 16'h0000);
    give_verdict();
  end
endmodule : pisc_top_tb
